// file: srf_defines.svh
// Register offsets, reset values, field positions and sizes of the result buffer
`ifndef SRF_DEFINES_SVH
`define SRF_DEFINES_SVH

`define SRF_ADDR_CFG        8'hDF
`define SRF_ADDR_MAP        8'hFC
`define SRF_ADDR_LVL        8'hFD
`define SRF_ADDR_DLO        8'hFE
`define SRF_ADDR_DHI        8'hFF

`define SRF_CFG_FLK_BIT     7
`define SRF_CFG_RSVD        7'h21
`define SRF_MAP_RESET       7'h00
`define SRF_MAP_STATUS_BIT  0
`define SRF_MAP_CH5_BIT     6

`define SRF_DEPTH           128
`define SRF_PTR_W           7
`define SRF_LVL_FULL        8'h80
`define SRF_LVL_ZERO        8'h00
`define SRF_STAGE_DEPTH     8
`define SRF_LAST_ITEM       3'h6
`define SRF_NUM_CH          6

`endif

// file: srf_host_model.sv
// Register-port driver standing in for the serial host
`timescale 1ns/1ps
`include "srf_defines.svh"
module srf_host_model (
    input  wire logic              clk,
    output srf_pkg::srf_host_req_t hostReq,
    input  wire logic [7:0]        hostRdData
);
    import srf_pkg::*;
    initial hostReq = '0;
    // One strobe per byte, launched and dropped on falling edges
    task automatic xfer(input srf_host_req_t q, output logic [7:0] d);
        @(negedge clk);
        hostReq = q;
        @(negedge clk);
        hostReq = '0;
        d = hostRdData;
    endtask
    task automatic ld(input logic [7:0] a);
        logic [7:0] d;
        xfer(srf_host_req_t'{1'b1, a, 1'b0, 8'h00, 1'b0}, d);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic [7:0] d;
        ld(a);
        xfer(srf_host_req_t'{1'b0, 8'h00, 1'b1, v, 1'b0}, d);
    endtask
    task automatic rd(output logic [7:0] d);
        xfer(srf_host_req_t'{1'b0, 8'h00, 1'b0, 8'h00, 1'b1}, d);
    endtask
    // Reserved config bits go back with their default pattern
    task automatic cfg(input logic f);
        wr(`SRF_ADDR_CFG, {f, `SRF_CFG_RSVD});
    endtask
endmodule

// file: srf_pkg.sv
// Types shared by the result buffer and its host-facing register port
package srf_pkg;

    // Packer states
    typedef enum logic [1:0] {
        SRF_IDLE = 2'b00,
        SRF_RUN  = 2'b01
    } srf_state_t;

    // One measurement cycle as delivered by the sequencer
    typedef struct packed {
        logic [7:0]        status;
        logic [5:0][15:0]  ch;
    } srf_meas_t;

    // Byte-wide register access from the serial protocol engine
    typedef struct packed {
        logic       addrLoad;
        logic [7:0] addr;
        logic       wr;
        logic [7:0] wrData;
        logic       rd;
    } srf_host_req_t;

endpackage

// file: srf_result_fifo.sv
// Spectral result buffer: capture packer, 128-entry store and host register window
//
// Function
// - Store 128 two-byte entries (256 bytes) in arrival order.
// - Entry arriving when 128 are unread sets overflow and is dropped.
// - Host reads buffered data at 0xFE (low byte) and 0xFF (high byte).
// - Register pointer wraps from 0xFF back to 0xFE on sequential access.
// - Single-byte reads and bursts of any length are both accepted.
// - Single-byte read of 0xFF advances read pointer and lowers level.
// - Bursts advance pointer and lower level once per two-byte entry.
// - Reading data with level zero returns zero and leaves read pointer and level unchanged.
// - Data interrupt indication is high while unread data is held.
// - Read-only 8-bit fill level counts unread entries, 0 to 128.
// - Capture map bits 1 to 6 enable channels 0 to 5, two bytes each.
// - Capture map bit 0 enables the status byte, one byte per sample.
// - Channel 5 capture enable is ignored while flicker detection runs.
// - Config bit 7 captures flicker raw bytes, only with flicker detection on.
// - All capture map enables reset to zero.
`timescale 1ns/1ps
`include "srf_defines.svh"
module srf_result_fifo (
    input  wire logic                   clk,
    input  wire logic                   resetn,
    input  wire srf_pkg::srf_host_req_t hostReq,
    output logic [7:0]                  hostRdData,
    input  wire logic                   measValid,
    output logic                        measReady,
    input  wire srf_pkg::srf_meas_t     measData,
    input  wire logic                   flickerValid,
    output logic                        flickerReady,
    input  wire logic [7:0]             flickerByte,
    input  wire logic                   flickerDetectEnable,
    input  wire logic                   overflowClear,
    output logic                        overflowFlag,
    output logic                        bufferDataIrq,
    output logic [7:0]                  bufferFillLevel
);
    import srf_pkg::*;

    // Register state
    logic [7:0]       ptr_q;
    logic [7:0]       ptr_d;
    logic             flkCapture_q;
    logic [6:0]       captureMap_q;
    logic [7:0]       rdData_q;
    logic [7:0]       rdData_d;

    // Main store
    logic [15:0]      store [`SRF_DEPTH];
    logic [`SRF_PTR_W-1:0] wrPtr_q;
    logic [`SRF_PTR_W-1:0] rdPtr_q;
    logic [7:0]       level_q;
    logic [7:0]       level_d;
    logic             overflow_q;

    // Packer state
    srf_state_t       state_q;
    logic [2:0]       item_q;
    srf_meas_t        snap_q;
    logic [7:0]       half_q;
    logic             halfValid_q;
    logic [7:0]       half_d;
    logic             halfValid_d;

    // Staging FIFO handshakes
    wire              stageInReady;
    wire              stageOutValid;
    wire [15:0]       stageOutData;
    wire              stageOutReady;

    // ------------------------------------------------------------------
    // Effective capture enables per measurement item
    // ------------------------------------------------------------------
    wire [6:0] itemEn;
    assign itemEn[`SRF_MAP_STATUS_BIT] = captureMap_q[`SRF_MAP_STATUS_BIT];
    assign itemEn[5:1] = captureMap_q[5:1];
    assign itemEn[`SRF_MAP_CH5_BIT] = captureMap_q[`SRF_MAP_CH5_BIT]
                                      & ~flickerDetectEnable;

    // ------------------------------------------------------------------
    // Packer input selection: measurement item in RUN, flicker byte in IDLE
    // ------------------------------------------------------------------
    wire        isRun;
    wire        flkTake;
    wire [2:0]  chIdx;
    wire [15:0] itemWord;
    wire        inActive;
    wire        inOne;
    wire [7:0]  inLo;
    wire [7:0]  inHi;
    wire        needPush;
    wire [15:0] pushWord;
    wire        stall;

    assign isRun        = (state_q == SRF_RUN);
    assign measReady    = ~isRun;
    // Measurement start wins over a flicker byte offered in the same cycle
    assign flickerReady = ~isRun & ~measValid & stageInReady;
    assign flkTake      = flickerValid & flickerReady & flickerDetectEnable
                          & flkCapture_q;
    assign chIdx        = item_q - 3'h1;
    assign itemWord     = (item_q == 3'h0) ? {8'h00, snap_q.status}
                                           : snap_q.ch[chIdx];
    assign inActive     = isRun ? itemEn[item_q] : flkTake;
    assign inOne        = isRun ? (item_q == 3'h0) : 1'b1;
    assign inLo         = isRun ? itemWord[7:0] : flickerByte;
    assign inHi         = itemWord[15:8];

    // Earlier byte goes low; an odd byte waits for its partner
    assign needPush = inActive & (halfValid_q | ~inOne);
    assign pushWord = halfValid_q ? {inLo, half_q} : {inHi, inLo};
    // Back-pressure from the staging FIFO freezes the packer
    assign stall    = needPush & ~stageInReady;

    // Pending half byte bookkeeping
    always_comb begin
        half_d      = half_q;
        halfValid_d = halfValid_q;
        if (inActive && !stall) begin
            if (inOne) begin
                half_d      = inLo;
                halfValid_d = ~halfValid_q;
            end else if (halfValid_q) begin
                half_d      = inHi;
            end
        end
    end

    // Packer sequencer walks items 0..6 in fixed order, one per cycle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q <= SRF_IDLE;
            item_q  <= 3'h0;
        end else begin
            case (state_q)
                SRF_IDLE: begin
                    if (measValid) begin
                        state_q <= SRF_RUN;
                        item_q  <= 3'h0;
                    end
                end
                SRF_RUN: begin
                    if (!stall) begin
                        item_q <= item_q + 3'h1;
                        if (item_q == `SRF_LAST_ITEM) begin
                            state_q <= SRF_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= SRF_IDLE;
                end
            endcase
        end
    end

    // Snapshot lets the sequencer move on while results are queued
    always_ff @(posedge clk) begin
        if (!resetn) begin
            snap_q      <= '0;
            half_q      <= 8'h00;
            halfValid_q <= 1'b0;
        end else begin
            if (!isRun && measValid) begin
                snap_q <= measData;
            end
            half_q      <= half_d;
            halfValid_q <= halfValid_d;
        end
    end

    // Eight-entry staging queue between packer and main store
    srf_stage_fifo #(
        .WIDTH (16),
        .DEPTH (`SRF_STAGE_DEPTH)
    ) u_stage (
        .clk      (clk),
        .resetn   (resetn),
        .inValid  (needPush),
        .inReady  (stageInReady),
        .inData   (pushWord),
        .outValid (stageOutValid),
        .outReady (stageOutReady),
        .outData  (stageOutData)
    );

    // ------------------------------------------------------------------
    // Host register window decode
    // ------------------------------------------------------------------
    wire hitCfg;
    wire hitMap;
    wire hitLvl;
    wire hitDlo;
    wire hitDhi;
    wire notEmpty;
    wire isFull;
    wire popNow;
    wire storeWr;
    wire dropNow;
    wire access;

    assign hitCfg   = (ptr_q == `SRF_ADDR_CFG);
    assign hitMap   = (ptr_q == `SRF_ADDR_MAP);
    assign hitLvl   = (ptr_q == `SRF_ADDR_LVL);
    assign hitDlo   = (ptr_q == `SRF_ADDR_DLO);
    assign hitDhi   = (ptr_q == `SRF_ADDR_DHI);
    assign notEmpty = (level_q != `SRF_LVL_ZERO);
    assign isFull   = (level_q == `SRF_LVL_FULL);
    assign access   = hostReq.rd | hostReq.wr;

    // Pop on every high-byte read while data is held; a burst from 0xFE pops once per entry
    assign popNow = hostReq.rd & hitDhi & notEmpty;

    // Single-port store: drain pauses on a pop cycle, stage absorbs it
    assign stageOutReady = ~popNow;
    assign storeWr       = stageOutValid & stageOutReady & ~isFull;
    assign dropNow       = stageOutValid & stageOutReady & isFull;

    // Pointer auto-increments, but 0xFF folds back to 0xFE
    always_comb begin
        ptr_d = ptr_q;
        if (hostReq.addrLoad) begin
            ptr_d = hostReq.addr;
        end else if (access) begin
            ptr_d = hitDhi ? `SRF_ADDR_DLO : ptr_q + 8'h01;
        end
    end

    // Read mux; empty store reads as zero
    always_comb begin
        rdData_d = rdData_q;
        if (hostReq.rd) begin
            rdData_d = 8'h00;
            if (hitCfg) begin
                rdData_d = {flkCapture_q, `SRF_CFG_RSVD};
            end else if (hitMap) begin
                rdData_d = {1'b0, captureMap_q};
            end else if (hitLvl) begin
                rdData_d = level_q;
            end else if (hitDlo && notEmpty) begin
                rdData_d = store[rdPtr_q][7:0];
            end else if (hitDhi && notEmpty) begin
                rdData_d = store[rdPtr_q][15:8];
            end
        end
    end

    // Host-visible registers and pointer
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ptr_q        <= 8'h00;
            rdData_q     <= 8'h00;
            flkCapture_q <= 1'b0;
            captureMap_q <= `SRF_MAP_RESET;
        end else begin
            ptr_q    <= ptr_d;
            rdData_q <= rdData_d;
            // Reserved config bits are fixed; written values are not kept
            if (hostReq.wr && hitCfg) begin
                flkCapture_q <= hostReq.wrData[`SRF_CFG_FLK_BIT];
            end
            if (hostReq.wr && hitMap) begin
                captureMap_q <= hostReq.wrData[6:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Main store, level and overflow
    // ------------------------------------------------------------------
    always_comb begin
        level_d = level_q;
        if (storeWr && !popNow) begin
            level_d = level_q + 8'h01;
        end else if (popNow && !storeWr) begin
            level_d = level_q - 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (storeWr) begin
            store[wrPtr_q] <= stageOutData;
        end
    end

    // Overflow set beats a clear arriving in the same cycle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wrPtr_q    <= '0;
            rdPtr_q    <= '0;
            level_q    <= 8'h00;
            overflow_q <= 1'b0;
        end else begin
            wrPtr_q <= wrPtr_q + `SRF_PTR_W'(storeWr);
            rdPtr_q <= rdPtr_q + `SRF_PTR_W'(popNow);
            level_q <= level_d;
            if (dropNow) begin
                overflow_q <= 1'b1;
            end else if (overflowClear) begin
                overflow_q <= 1'b0;
            end
        end
    end

    // Outputs
    assign hostRdData      = rdData_q;
    assign overflowFlag    = overflow_q;
    assign bufferFillLevel = level_q;
    assign bufferDataIrq   = notEmpty;
endmodule

// file: srf_result_fifo_sva.sv
// Port-level assertions for the result buffer
`timescale 1ns/1ps
module srf_result_fifo_chk (
    input wire logic                   clk,
    input wire logic                   resetn,
    input wire srf_pkg::srf_host_req_t hostReq,
    input wire logic [7:0]             hostRdData,
    input wire logic                   measValid,
    input wire logic                   measReady,
    input wire srf_pkg::srf_meas_t     measData,
    input wire logic                   flickerValid,
    input wire logic                   flickerReady,
    input wire logic [7:0]             flickerByte,
    input wire logic                   flickerDetectEnable,
    input wire logic                   overflowClear,
    input wire logic                   overflowFlag,
    input wire logic                   bufferDataIrq,
    input wire logic [7:0]             bufferFillLevel
);
    import srf_pkg::*;
    logic [7:0] ptr_q;
    logic [7:0] ptr_d;
    logic       inWin;
    // Shadow pointer; the data window folds 0xFF back so bursts keep draining
    assign ptr_d = hostReq.addrLoad ? hostReq.addr : !(hostReq.rd || hostReq.wr) ? ptr_q :
                   (ptr_q == 8'hFF) ? 8'hFE : ptr_q + 8'h01;
    assign inWin = ptr_q[7:1] == 7'h7F;
    always_ff @(posedge clk) begin
        if (!resetn)
            ptr_q <= 8'h00;
        else
            ptr_q <= ptr_d;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_irq_level: assert property (bufferDataIrq == (bufferFillLevel != 8'h00))
        else $error("irq does not follow the fill level");
    a_level_max: assert property (bufferFillLevel <= 8'h80)
        else $error("fill level above 128");
    a_level_step: assert property (1'b1 |=>
        8'(bufferFillLevel - $past(bufferFillLevel)) inside {8'h00, 8'h01, 8'hFF})
        else $error("fill level jumped by more than one");
    a_low_nopop: assert property (hostReq.rd && ptr_q == 8'hFE |=>
        bufferFillLevel >= $past(bufferFillLevel)) else $error("low byte read popped");
    a_empty_zero: assert property (hostReq.rd && inWin && bufferFillLevel == 8'h00 |=>
        hostRdData == 8'h00) else $error("empty window read not zero");
    a_rd_hold: assert property (!hostReq.rd |=> $stable(hostRdData))
        else $error("read data changed without a read");
    a_ovf_hold: assert property (overflowFlag && !overflowClear |=> overflowFlag)
        else $error("overflow flag dropped on its own");
    a_ovf_full: assert property ($rose(overflowFlag) |-> $past(bufferFillLevel) == 8'h80)
        else $error("overflow raised below full");
    a_meas_busy: assert property (measValid && measReady |=> !measReady [*7])
        else $error("packer accepted within seven cycles");
endmodule
bind srf_result_fifo srf_result_fifo_chk u_srf_result_fifo_chk (
    .clk, .resetn, .hostReq, .hostRdData, .measValid, .measReady, .measData, .flickerValid,
    .flickerReady, .flickerByte, .flickerDetectEnable, .overflowClear, .overflowFlag,
    .bufferDataIrq, .bufferFillLevel
);

// file: srf_result_fifo_tb_top.sv
// Self-checking bench for the spectral result buffer
`timescale 1ns/1ps
`include "srf_defines.svh"
module srf_result_fifo_tb_top;
    import srf_pkg::*;
    logic          clk, measReady, flickerReady, overflowFlag, bufferDataIrq;
    logic          resetn = 1'b0, measValid = 1'b0, flickerValid = 1'b0;
    logic          flickerDetectEnable = 1'b0, overflowClear = 1'b0;
    logic [7:0]    flickerByte = 8'h00, hostRdData, bufferFillLevel, pend, mapV, b;
    srf_host_req_t hostReq;
    srf_meas_t     measData = '0;
    logic [15:0]   eq[$];
    logic [31:0]   rng = 32'h4, t;
    bit            hasPend, flkV, ovf;
    int            errCount, checkCount, cyc;

    srf_result_fifo u_srf_result_fifo (
        .clk, .resetn, .hostReq, .hostRdData, .measValid, .measReady, .measData,
        .flickerValid, .flickerReady, .flickerByte, .flickerDetectEnable,
        .overflowClear, .overflowFlag, .bufferDataIrq, .bufferFillLevel
    );
    srf_host_model u_srf_host_model (.clk, .hostReq, .hostRdData);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Hang guard; the whole run needs well under half of this
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            errCount++;
            finishTest();
        end
    end
    function automatic logic [31:0] nxt();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checkCount++;
        if (got !== exp) begin
            errCount++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Byte stream into entries; the odd byte waits, earlier byte lands low
    task automatic put8(input logic [7:0] v);
        if (!hasPend) begin
            pend = v;
            hasPend = 1'b1;
        end else begin
            hasPend = 1'b0;
            if (eq.size() < `SRF_DEPTH)
                eq.push_back({v, pend});
            else
                ovf = 1'b1;
        end
    endtask
    // One measurement cycle; returns once the packer is idle and the store settled
    task automatic meas();
        logic [127:0] r;
        r = {nxt(), nxt(), nxt(), nxt()};
        measData = r[103:0];
        measValid = 1'b1;
        @(negedge clk);
        measValid = 1'b0;
        if (mapV[0]) put8(measData.status);
        for (int i = 0; i < 6; i++) begin
            if (mapV[i+1] && !(i == 5 && flickerDetectEnable)) begin
                put8(measData.ch[i][7:0]);
                put8(measData.ch[i][15:8]);
            end
        end
        for (int k = 0; k < 40 && (!measReady || bufferFillLevel !== 8'(eq.size())); k++)
            @(negedge clk);
        repeat (4) @(negedge clk);
    endtask
    task automatic flk(input int n);
        flickerValid = 1'b1;
        repeat (n) begin
            t = nxt();
            flickerByte = t[7:0];
            for (int k = 0; k < 40 && !flickerReady; k++) @(negedge clk);
            @(negedge clk);
            if (flickerDetectEnable && flkV) put8(flickerByte);
        end
        flickerValid = 1'b0;
        repeat (6) @(negedge clk);
    endtask
    // Sequential window reads with no reload, relying on the pointer fold
    task automatic drain(input int n);
        logic [7:0] lo;
        logic [7:0] hi;
        u_srf_host_model.ld(`SRF_ADDR_DLO);
        repeat (n) begin
            u_srf_host_model.rd(lo);
            u_srf_host_model.rd(hi);
            chk({hi, lo}, (eq.size() > 0) ? eq.pop_front() : 16'h0000);
            chk(16'(bufferFillLevel), 16'(eq.size()));
        end
    endtask
    task automatic finishTest();
        $display("Checks %0d, mismatches %0d", checkCount, errCount);
        if (errCount == 0 && checkCount > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        // Reset values, a write to the read-only level, an unmapped hole
        u_srf_host_model.wr(`SRF_ADDR_LVL, 8'h5A);
        u_srf_host_model.ld(`SRF_ADDR_CFG);
        u_srf_host_model.rd(b);
        chk(16'(b), 16'h0021);
        u_srf_host_model.rd(b);
        chk(16'(b), 16'h0000);
        u_srf_host_model.ld(`SRF_ADDR_MAP);
        for (int i = 0; i < 5; i++) begin
            u_srf_host_model.rd(b);
            chk(16'(b), 16'h0000);
        end
        // Source maps: all sources with detection off and on, then random
        for (int r = 0; r < 8; r++) begin
            t = nxt();
            mapV = (r < 2) ? 8'h7F : {1'b0, t[6:0]};
            flkV = t[9] | (r < 2);
            flickerDetectEnable = (r < 2) ? r[0] : t[8];
            u_srf_host_model.wr(`SRF_ADDR_MAP, mapV);
            u_srf_host_model.cfg(flkV);
            // Read back both source registers; the flicker bit must stick
            u_srf_host_model.ld(`SRF_ADDR_CFG);
            u_srf_host_model.rd(b);
            chk(16'(b), 16'({flkV, `SRF_CFG_RSVD}));
            u_srf_host_model.ld(`SRF_ADDR_MAP);
            u_srf_host_model.rd(b);
            chk(16'(b), 16'(mapV));
            repeat (3) meas();
            flk(3);
            drain(eq.size());
        end
        // Fill past 128 entries, then drain the survivors in order
        mapV = 8'h02;
        flickerDetectEnable = 1'b0;
        u_srf_host_model.wr(`SRF_ADDR_MAP, mapV);
        repeat (130) meas();
        chk(16'(bufferFillLevel), 16'h0080);
        chk(16'(overflowFlag), 16'(ovf));
        drain(3);
        overflowClear = 1'b1;
        @(negedge clk);
        overflowClear = 1'b0;
        ovf = 1'b0;
        chk(16'(overflowFlag), 16'h0000);
        drain(eq.size() + 1);
        chk(16'(bufferDataIrq), 16'h0000);
        finishTest();
    end
endmodule

// file: srf_stage_fifo.sv
// Small staging FIFO with valid/ready on both sides
`timescale 1ns/1ps
module srf_stage_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_q;
    logic [AW-1:0]    rdPtr_q;
    logic [AW:0]      count_q;
    wire              doPush;
    wire              doPop;

    // Full and empty straight from the occupancy count
    assign inReady  = (count_q != (AW+1)'(DEPTH));
    assign outValid = (count_q != '0);
    assign outData  = mem[rdPtr_q];
    assign doPush   = inValid & inReady;
    assign doPop    = outValid & outReady;

    // Storage has no reset; only pointers and the count need a defined state
    always_ff @(posedge clk) begin
        if (doPush) begin
            mem[wrPtr_q] <= inData;
        end
    end

    // Pointers wrap naturally since DEPTH is a power of two
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            wrPtr_q <= wrPtr_q + AW'(doPush);
            rdPtr_q <= rdPtr_q + AW'(doPop);
            count_q <= count_q + (AW+1)'(doPush) - (AW+1)'(doPop);
        end
    end
endmodule
